// file: spi_controller_timing_sequencer.sv
// Notes on behaviour
// - Controller bit 0 of global control enables driving clock and chip select.
// - Format bit 16 selects the shifted sampling phase.
// - Format bit 17 picks the active clock edge and the idle clock level.
// - Serial clock period is prescale plus one bus cycles (two at prescale zero), prescale in bits 15:8.
// - First clock edge comes half period plus select delay plus two after select.
// - Polarity one with keep-asserted uses select delay plus three instead.
// - Select stays active deselect delay plus one cycles after the last edge.
// - Both delays come from fields of the delay control word.
// - Shifted phase samples on falling edge at polarity zero, rising at one.
`timescale 1ns/100ps
`include "spi_ctrl_defs.svh"

module spi_controller_timing_sequencer
	import spi_ctrl_pkg::*;
(
	// Clock and reset
	input  wire logic        ref_clk,
	input  wire logic        rst,
	// Control words
	input  wire logic [31:0] spiGlobalControl,
	input  wire logic [31:0] spiFormatControl,
	input  wire logic [31:0] spiDelayControl,
	input  wire logic        selectKeepAsserted,
	// Outbound words
	input  wire logic        txValid,
	output logic             txReady,
	input  wire spi_word_t   txData,
	// Inbound words
	output logic             rxValid,
	input  wire logic        rxReady,
	output spi_word_t        rxData,
	// Status
	output logic             busy,
	// Serial pins
	output logic             serialClockPin,
	output logic             serialClockOe,
	output logic             ctrlOutData,
	output logic             ctrlOutOe,
	input  wire logic        ctrlInData,
	output logic             chipSelectN,
	output logic             chipSelectOe
);

	// ****************************************************************
	// Field decoding
	// ****************************************************************
	function automatic logic [8:0] periodOf(input logic [7:0] ps);
		// A zero prescale would give a one cycle period; it runs at two instead
		if (ps == 8'h00) begin
			periodOf = `PRESCALE_ZERO_PERIOD;
		end else begin
			periodOf = {1'b0, ps} + 9'h001;
		end
	endfunction

	logic       ctrlEnable;
	logic       phaseShift;
	logic       polarity;
	logic [8:0] period;
	logic [8:0] loHalf;
	logic [8:0] hiHalf;
	logic [7:0] selToClk;
	logic [7:0] clkToDesel;
	logic [9:0] leadCycles;

	assign ctrlEnable = spiGlobalControl[`GLB_CONTROLLER_BIT];
	assign phaseShift = spiFormatControl[`FMT_PHASE_BIT];
	assign polarity   = spiFormatControl[`FMT_POLARITY_BIT];
	assign period     = periodOf(spiFormatControl[`FMT_PRESCALE_MSB:`FMT_PRESCALE_LSB]);
	assign loHalf     = {1'b0, period[8:1]};
	assign hiHalf     = period - loHalf;
	assign selToClk   = spiDelayControl[`DLY_SEL2CLK_MSB:`DLY_SEL2CLK_LSB];
	assign clkToDesel = spiDelayControl[`DLY_CLK2DESEL_MSB:`DLY_CLK2DESEL_LSB];

	always_comb begin
		leadCycles = {2'b00, period[8:1]} + {2'h0, selToClk};
		if (polarity && selectKeepAsserted) begin
			leadCycles = leadCycles + `LEAD_EXTRA_KEEP_POL1;
		end else begin
			leadCycles = leadCycles + `LEAD_EXTRA_CYCLES;
		end
	end

	// ****************************************************************
	// Inbound buffer
	// ****************************************************************
	// The sequencer only starts a word when a slot is free, so a stalled
	// receiver holds off the link rather than losing a word
	logic      rxPush;
	logic      rxSpace;
	spi_word_t rxWord;

	two_entry_buffer rxBuf (
		.ref_clk  (ref_clk),
		.rst      (rst),
		.inValid  (rxPush),
		.inReady  (rxSpace),
		.inData   (rxWord),
		.outValid (rxValid),
		.outReady (rxReady),
		.outData  (rxData)
	);

	// ****************************************************************
	// Sequencer
	// ****************************************************************
	seq_state_t state_q;
	seq_state_t state_d;
	logic [9:0] cnt_q;
	logic [9:0] cnt_d;
	logic [5:0] edgeCnt_q;
	logic [5:0] edgeCnt_d;
	logic       sclk_q;
	logic       sclk_d;
	logic       csN_q;
	logic       csN_d;
	logic       outBit_q;
	logic       outBit_d;
	spi_word_t  txShift_q;
	spi_word_t  txShift_d;
	spi_word_t  rxShift_q;
	spi_word_t  rxShift_d;
	logic       startWord;
	logic       rxRoomAfterPush;
	logic       doEdge;
	logic       leading;
	logic       lastEdge;

	assign startWord = ctrlEnable && txValid && rxSpace;
	// A held follow-on word needs a slot left after the ending word is pushed,
	// otherwise a stalled receiver would lose the follow-on word
	assign rxRoomAfterPush = !rxValid || rxReady;
	assign txReady   = startWord && ((state_q == SEQ_IDLE) ||
	                   (state_q == SEQ_SHIFT && lastEdge && selectKeepAsserted && rxRoomAfterPush));
	assign doEdge    = (cnt_q == 10'h000) && ((state_q == SEQ_LEAD) || (state_q == SEQ_SHIFT));
	assign leading   = ~edgeCnt_q[0];
	assign lastEdge  = doEdge && (edgeCnt_q == `EDGES_PER_WORD - 6'h01);

	always_comb begin
		state_d   = state_q;
		cnt_d     = cnt_q;
		edgeCnt_d = edgeCnt_q;
		sclk_d    = sclk_q;
		csN_d     = csN_q;
		outBit_d  = outBit_q;
		txShift_d = txShift_q;
		rxShift_d = rxShift_q;
		rxPush    = 1'b0;
		rxWord    = rxShift_q;
		if (state_q != SEQ_SHIFT && state_q != SEQ_LEAD) begin
			sclk_d = polarity;
		end
		if (doEdge) begin
			sclk_d    = ~sclk_q;
			edgeCnt_d = edgeCnt_q + 6'h01;
			// Leading edge samples at phase zero, trailing edge at shifted phase
			if (leading != phaseShift) begin
				rxShift_d = {rxShift_q[14:0], ctrlInData};
			end else if (leading || !lastEdge) begin
				outBit_d  = txShift_q[15];
				txShift_d = {txShift_q[14:0], 1'b0};
			end
			cnt_d = {1'b0, (leading ? hiHalf : loHalf) - 9'h001};
			state_d = SEQ_SHIFT;
		end else if (cnt_q != 10'h000) begin
			cnt_d = cnt_q - 10'h001;
		end
		case (state_q)
			SEQ_IDLE: begin
				csN_d = 1'b1;
				if (startWord) begin
					csN_d   = 1'b0;
					state_d = SEQ_LEAD;
					cnt_d   = leadCycles - 10'h001;
				end
			end
			SEQ_LEAD: begin
			end
			SEQ_SHIFT: begin
				if (lastEdge) begin
					rxWord    = rxShift_d;
					rxPush    = 1'b1;
					edgeCnt_d = 6'h00;
					state_d   = SEQ_TRAIL;
					cnt_d     = {2'h0, clkToDesel};
					if (txReady) begin
						state_d = SEQ_LEAD;
						cnt_d   = leadCycles - 10'h001;
					end
				end
			end
			SEQ_TRAIL: begin
				if (cnt_q == 10'h000) begin
					csN_d   = 1'b1;
					state_d = SEQ_IDLE;
				end
			end
			default: begin
				state_d = SEQ_IDLE;
			end
		endcase
		if (txReady) begin
			// Phase zero puts the first bit out before the first edge
			edgeCnt_d = 6'h00;
			txShift_d = phaseShift ? txData : {txData[14:0], 1'b0};
			if (!phaseShift) begin
				outBit_d = txData[15];
			end
		end
		if (!ctrlEnable) begin
			// Dropping controller mode aborts any word in flight
			state_d   = SEQ_IDLE;
			csN_d     = 1'b1;
			sclk_d    = polarity;
			edgeCnt_d = 6'h00;
			cnt_d     = 10'h000;
			rxPush    = 1'b0;
		end
	end

	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			state_q   <= SEQ_IDLE;
			cnt_q     <= 10'h000;
			edgeCnt_q <= 6'h00;
			sclk_q    <= 1'b0;
			csN_q     <= 1'b1;
			outBit_q  <= 1'b0;
			txShift_q <= 16'h0000;
			rxShift_q <= 16'h0000;
		end else begin
			state_q   <= state_d;
			cnt_q     <= cnt_d;
			edgeCnt_q <= edgeCnt_d;
			sclk_q    <= sclk_d;
			csN_q     <= csN_d;
			outBit_q  <= outBit_d;
			txShift_q <= txShift_d;
			rxShift_q <= rxShift_d;
		end
	end

	// ****************************************************************
	// Pins
	// ****************************************************************
	assign serialClockPin = sclk_q;
	assign ctrlOutData    = outBit_q;
	assign chipSelectN    = csN_q;
	assign serialClockOe  = ctrlEnable;
	assign ctrlOutOe      = ctrlEnable;
	assign chipSelectOe   = ctrlEnable;
	assign busy           = (state_q != SEQ_IDLE);

endmodule

// file: spi_ctrl_defs.svh
`ifndef SPI_CTRL_DEFS_SVH
`define SPI_CTRL_DEFS_SVH

// ********************************************************************
// Control word layouts
// ********************************************************************
`define GLB_CONTROLLER_BIT   0
`define FMT_PHASE_BIT        16
`define FMT_POLARITY_BIT     17
`define FMT_PRESCALE_MSB     15
`define FMT_PRESCALE_LSB     8
`define DLY_SEL2CLK_MSB      31
`define DLY_SEL2CLK_LSB      24
`define DLY_CLK2DESEL_MSB    23
`define DLY_CLK2DESEL_LSB    16

// ********************************************************************
// Word and timing figures
// ********************************************************************
`define WORD_BITS            16
`define EDGES_PER_WORD       6'h20
`define PRESCALE_ZERO_PERIOD 9'h002
`define LEAD_EXTRA_CYCLES    10'h002
`define LEAD_EXTRA_KEEP_POL1 10'h003
`define MIN_SCLK_PERIOD_NS   25
`define REF_CLK_PERIOD_NS    10

`endif

// file: spi_ctrl_pkg.sv
package spi_ctrl_pkg;

	// Gray coded along idle -> lead -> shift -> trail -> idle
	typedef enum logic [1:0] {
		SEQ_IDLE  = 2'b00,
		SEQ_LEAD  = 2'b01,
		SEQ_SHIFT = 2'b11,
		SEQ_TRAIL = 2'b10
	} seq_state_t;

	typedef logic [15:0] spi_word_t;

endpackage

// file: two_entry_buffer.sv
`timescale 1ns/100ps

module two_entry_buffer
	import spi_ctrl_pkg::*;
(
	// Clock and reset
	input  wire logic      ref_clk,
	input  wire logic      rst,
	// Filling side
	input  wire logic      inValid,
	output logic           inReady,
	input  wire spi_word_t inData,
	// Draining side
	output logic           outValid,
	input  wire logic      outReady,
	output spi_word_t      outData
);

	spi_word_t slot_q [2];
	spi_word_t slot_d [2];
	logic      wrPtr_q;
	logic      wrPtr_d;
	logic      rdPtr_q;
	logic      rdPtr_d;
	logic [1:0] count_q;
	logic [1:0] count_d;
	logic       push;
	logic       pop;

	assign inReady  = (count_q != 2'h2);
	assign outValid = (count_q != 2'h0);
	assign outData  = slot_q[rdPtr_q];

	always_comb begin
		push   = inValid && inReady;
		pop    = outValid && outReady;
		slot_d = slot_q;
		wrPtr_d = wrPtr_q;
		rdPtr_d = rdPtr_q;
		count_d = count_q;
		if (push) begin
			slot_d[wrPtr_q] = inData;
			wrPtr_d = ~wrPtr_q;
		end
		if (pop) begin
			rdPtr_d = ~rdPtr_q;
		end
		if (push && !pop) begin
			count_d = count_q + 2'h1;
		end else if (pop && !push) begin
			count_d = count_q - 2'h1;
		end
	end

	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			slot_q[0] <= 16'h0000;
			slot_q[1] <= 16'h0000;
			wrPtr_q   <= 1'b0;
			rdPtr_q   <= 1'b0;
			count_q   <= 2'h0;
		end else begin
			slot_q  <= slot_d;
			wrPtr_q <= wrPtr_d;
			rdPtr_q <= rdPtr_d;
			count_q <= count_d;
		end
	end

endmodule

// file: spi_seq_props.sv
`timescale 1ns/100ps
module spi_seq_props
	import spi_ctrl_pkg::*;
(
	// Clock, reset, controls
	input wire logic        ref_clk,
	input wire logic        rst,
	input wire logic [31:0] spiGlobalControl,
	input wire logic [31:0] spiFormatControl,
	input wire logic [31:0] spiDelayControl,
	input wire logic        selectKeepAsserted,
	// Outputs
	input wire logic        txReady,
	input wire logic        busy,
	input wire logic        serialClockPin,
	input wire logic        serialClockOe,
	input wire logic        ctrlOutOe,
	input wire logic        chipSelectOe,
	input wire logic        chipSelectN
);
	// ********
	// Edge and gap counters
	// ********
	logic [15:0] lead_q, gap_q, edges_q, per, want;
	logic        pin_q, tog;
	assign per = (spiFormatControl[15:8] == 8'h00) ? 16'h0002 : {8'h00, spiFormatControl[15:8]} + 16'h0001;
	assign want = (per >> 1) + {8'h00, spiDelayControl[31:24]}
		+ ((spiFormatControl[17] && selectKeepAsserted) ? 16'h0003 : 16'h0002);
	assign tog = serialClockPin ^ pin_q;
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			pin_q <= 1'b0;
			lead_q <= 16'h0000;
			gap_q <= 16'h0000;
			edges_q <= 16'h0000;
		end else begin
			pin_q <= serialClockPin;
			lead_q <= chipSelectN ? 16'h0000 : lead_q + 16'h0001;
			gap_q <= tog ? 16'h0001 : gap_q + 16'h0001;
			edges_q <= chipSelectN ? 16'h0000 : edges_q + {15'h0000, tog};
		end
	end
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (rst);
	sequence take_s; txReady && !busy; endsequence
	sequence first_s; tog && !chipSelectN && edges_q == 16'h0000; endsequence
	// Enable cleared in mid-word also raises select, so it is left out here
	sequence release_s; $rose(chipSelectN) && $past(spiGlobalControl[0]); endsequence
	oe_follow_a: assert property (serialClockOe == spiGlobalControl[0])
		else $error("clock drive wrong");
	pin_drive_a: assert property (ctrlOutOe == spiGlobalControl[0] && chipSelectOe == spiGlobalControl[0])
		else $error("pin drive wrong");
	take_off_a: assert property (!spiGlobalControl[0] |-> !txReady)
		else $error("take while off");
	abort_desel_a: assert property (!spiGlobalControl[0] |=> chipSelectN)
		else $error("select kept while off");
	busy_refuse_a: assert property (busy && !selectKeepAsserted |-> !txReady)
		else $error("take while busy");
	select_follow_a: assert property (take_s |=> !chipSelectN && busy)
		else $error("select late");
	lead_wait_a: assert property (first_s |-> lead_q == want)
		else $error("lead wait wrong");
	half_period_a: assert property (tog && !chipSelectN && edges_q[4:0] != 5'h00 |->
		gap_q == (edges_q[0] ? per - (per >> 1) : per >> 1)) else $error("half period wrong");
	trail_hold_a: assert property (release_s |-> gap_q == {8'h00, spiDelayControl[23:16]} + 16'h0001)
		else $error("trail wait wrong");
	word_edges_a: assert property (release_s |-> edges_q[4:0] == 5'h00 && edges_q != 16'h0000)
		else $error("edge count wrong");
endmodule
bind spi_controller_timing_sequencer spi_seq_props spi_seq_props_inst (.ref_clk(ref_clk), .rst(rst),
	.spiGlobalControl(spiGlobalControl), .spiFormatControl(spiFormatControl), .spiDelayControl(spiDelayControl),
	.selectKeepAsserted(selectKeepAsserted), .txReady(txReady), .busy(busy), .serialClockPin(serialClockPin),
	.serialClockOe(serialClockOe), .ctrlOutOe(ctrlOutOe), .chipSelectOe(chipSelectOe), .chipSelectN(chipSelectN));

// file: spi_peripheral_model.sv
`timescale 1ns/100ps
module spi_peripheral_model
	import spi_ctrl_pkg::*;
(
	// Serial pins
	input wire logic      ref_clk,
	input wire logic      serialClockPin,
	input wire logic      chipSelectN,
	input wire logic      ctrlOutData,
	output logic          ctrlInData,
	// Mode and words
	input wire logic      polarity,
	input wire logic      phase,
	input wire spi_word_t sendWord,
	output logic          gotStrobe,
	output spi_word_t     gotWord
);
	// ********
	// Shift on one edge, sample on the other
	// ********
	logic      csPrev = 1'b1;
	logic      pinPrev = 1'b0;
	spi_word_t w = 16'h0000;
	spi_word_t g = 16'h0000;
	int        k = 0;
	int        m = 0;
	initial begin
		ctrlInData = 1'b0;
		gotStrobe = 1'b0;
	end
	always @(posedge ref_clk) begin
		csPrev <= chipSelectN;
		pinPrev <= serialClockPin;
		gotStrobe <= 1'b0;
		if (chipSelectN) begin
			// Deselected line shows no stale bit
			ctrlInData <= ~ctrlInData;
			m <= 0;
		end else if (csPrev) begin
			k <= phase ? 0 : 1;
			w <= sendWord;
			if (!phase) ctrlInData <= sendWord[15];
		end else if (serialClockPin != pinPrev && (serialClockPin != polarity) == phase) begin
			// Word boundary under a held select reloads the next word
			k <= (k == 16) ? 1 : k + 1;
			if (k == 16) w <= sendWord;
			ctrlInData <= (k == 16) ? sendWord[15] : w[15 - k];
		end else if (serialClockPin != pinPrev) begin
			g <= {g[14:0], ctrlOutData};
			gotStrobe <= (m == 15);
			gotWord <= {g[14:0], ctrlOutData};
			m <= (m == 15) ? 0 : m + 1;
		end
	end
endmodule

// file: test_spi_controller_timing_sequencer.sv
`timescale 1ns/100ps
module test_spi_controller_timing_sequencer
	import spi_ctrl_pkg::*;
;
	// ********
	// Stimulus and reference queues
	// ********
	logic        ref_clk = 1'b0, rst = 1'b1, keep = 1'b0, txValid = 1'b0, rxReady = 1'b1, csPrev = 1'b1;
	logic        txReady, rxValid, busy, sclk, csN, outBit, inBit, gotStrobe;
	logic [31:0] glb = 32'h0000_0001, fmt = 32'h0000_0300, dly = 32'h0000_0000;
	spi_word_t   txData = 16'h0000, sendWord = 16'h0000, rxData, gotWord;
	spi_word_t   rxQ[$], txQ[$];
	int          errors, n_compared, csRises, i, n0, seed = 90;
	spi_controller_timing_sequencer spi_controller_timing_sequencer_inst (.ref_clk(ref_clk), .rst(rst),
		.spiGlobalControl(glb), .spiFormatControl(fmt), .spiDelayControl(dly), .selectKeepAsserted(keep),
		.txValid(txValid), .txReady(txReady), .txData(txData), .rxValid(rxValid), .rxReady(rxReady),
		.rxData(rxData), .busy(busy), .serialClockPin(sclk), .serialClockOe(), .ctrlOutData(outBit),
		.ctrlOutOe(), .ctrlInData(inBit), .chipSelectN(csN), .chipSelectOe());
	spi_peripheral_model spi_peripheral_model_inst (.ref_clk(ref_clk), .serialClockPin(sclk), .chipSelectN(csN),
		.ctrlOutData(outBit), .ctrlInData(inBit), .polarity(fmt[17]), .phase(fmt[16]), .sendWord(sendWord),
		.gotStrobe(gotStrobe), .gotWord(gotWord));
	always #5 ref_clk = ~ref_clk;
	task complete_run;
		$display("errors %0d compared %0d", errors, n_compared);
		if (errors == 0 && n_compared > 0) $display("== PASSED ==");
		else $display("== FAILED ==");
		$finish;
	endtask
	task compare(input spi_word_t got, input spi_word_t exp);
		n_compared++;
		if (got !== exp) begin
			errors++;
			$display("mismatch at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task xfer(input logic take);
		int t;
		spi_word_t d, p;
		d = 16'($random(seed));
		p = 16'($random(seed));
		@(posedge ref_clk);
		txValid <= 1'b1;
		txData <= d;
		sendWord <= p;
		for (t = 0; t < 1500; t++) begin
			@(posedge ref_clk);
			if (txReady === 1'b1) break;
		end
		txValid <= 1'b0;
		compare({15'h0000, t < 1500}, {15'h0000, take});
		if (t == 1500 && take) complete_run;
		if (t < 1500) begin
			txQ.push_back(d);
			rxQ.push_back(p);
		end
	endtask
	task settle(input logic drain);
		int t;
		rxReady <= drain;
		repeat (2) @(posedge ref_clk);
		for (t = 0; t < 3000 && (busy !== 1'b0 || (drain && rxValid !== 1'b0)); t++) @(posedge ref_clk);
		if (t == 3000) begin
			errors++;
			complete_run;
		end
	endtask
	always @(posedge ref_clk) begin
		csPrev <= csN;
		if (csN && !csPrev) csRises++;
		if (rxValid === 1'b1 && rxReady === 1'b1) compare(rxData, rxQ.pop_front());
		if (gotStrobe === 1'b1) compare(gotWord, txQ.pop_front());
	end
	initial begin
		repeat (2) @(posedge ref_clk);
		rst <= 1'b0;
		// All four modes, with and without held select
		for (i = 0; i < 8; i++) begin
			@(posedge ref_clk);
			fmt <= {14'h0000, i[1:0], {6'h00, 2'($random(seed))} + 8'h03, 8'h00};
			dly <= {5'h00, 3'($random(seed)), 5'h00, 3'($random(seed)), 16'h0000};
			keep <= i[2];
			rxReady <= 1'($random(seed));
			xfer(1'b1);
			settle(1'b1);
			compare({15'h0000, sclk}, {15'h0000, fmt[17]});
		end
		xfer(1'b1);
		repeat (20) @(posedge ref_clk);
		glb <= 32'h0000_0000;
		repeat (2) @(posedge ref_clk);
		compare({15'h0000, csN}, 16'h0001);
		void'(txQ.pop_back());
		void'(rxQ.pop_back());
		glb <= 32'h0000_0001;
		// Two held words fill the buffer, the third is refused
		keep <= 1'b1;
		rxReady <= 1'b0;
		// Let the abort's select rise be counted before taking the base
		@(posedge ref_clk);
		n0 = csRises;
		xfer(1'b1);
		xfer(1'b1);
		settle(1'b0);
		xfer(1'b0);
		compare(16'(csRises - n0), 16'h0001);
		settle(1'b1);
		// One word parked in the buffer leaves room for only one more, so no held follow-on word
		xfer(1'b1);
		settle(1'b0);
		xfer(1'b1);
		xfer(1'b0);
		settle(1'b1);
		complete_run;
	end
endmodule
